// file: src/prasq_pkg.sv
package prasq_pkg;

    localparam int unsigned PRASQ_ADDR_W   = 24;
    localparam int unsigned PRASQ_DWORD_W  = 64;
    localparam int unsigned PRASQ_INSTR_W  = 32;
    localparam int unsigned PRASQ_LEN_W    = 2;
    localparam int unsigned PRASQ_CNT_W    = 3;
    localparam int unsigned PRASQ_BYPASS_N = 3;

    localparam logic [PRASQ_ADDR_W-1:0] PRASQ_DWORD_BYTES = 24'h00_0008;
    localparam logic [PRASQ_ADDR_W-1:0] PRASQ_DWORD_MASK  = 24'hFF_FFF8;
    localparam logic [PRASQ_ADDR_W-1:0] PRASQ_RESET_PC    = 24'h00_0000;
    // Byte offset within a double word at which a 32-bit op would straddle
    localparam logic [2:0]              PRASQ_CROSS_OFS   = 3'h6;
    localparam logic [PRASQ_CNT_W-1:0]  PRASQ_CNT_ZERO    = 3'h0;
    localparam logic [PRASQ_CNT_W-1:0]  PRASQ_CNT_ONE     = 3'h1;
    localparam logic [1:0]              PRASQ_BYP_ZERO    = 2'h0;
    localparam logic [1:0]              PRASQ_BYP_LAST    = 2'h3;

    // Sequence-op kinds as seen by the decode stage
    typedef enum logic [2:0] {
        PRASQ_OP_NONE    = 3'b000,
        PRASQ_OP_ATOMIC  = 3'b001,
        PRASQ_OP_EXT_REG = 3'b010,
        PRASQ_OP_EXT_PG  = 3'b011,
        PRASQ_OP_EXT_SEG = 3'b100,
        PRASQ_OP_EXT_PGR = 3'b101,
        PRASQ_OP_EXT_SGR = 3'b110
    } prasq_op_e;

    typedef enum logic [1:0] {
        PRASQ_ADDR_NORMAL = 2'b00,
        PRASQ_ADDR_REG    = 2'b01,
        PRASQ_ADDR_PAGE   = 2'b10,
        PRASQ_ADDR_SEG    = 2'b11
    } prasq_amode_e;

    // Instruction retirement info from execute
    typedef struct packed {
        logic                   done;
        prasq_op_e              op;
        logic [PRASQ_LEN_W-1:0] len;
    } prasq_retire_s;

    // Program memory request
    typedef struct packed {
        logic                    req;
        logic [PRASQ_ADDR_W-1:0] addr;
    } prasq_pmreq_s;

endpackage : prasq_pkg

// file: src/prasq_seq_ctr.sv
module prasq_seq_ctr
    import prasq_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire prasq_retire_s retire,
    input  wire logic          trap_b,
    output logic               int_lock,
    output prasq_amode_e       amode
);

    logic [PRASQ_CNT_W-1:0] cnt_q, cnt_d;
    prasq_amode_e           mode_q, mode_d;

    function automatic prasq_amode_e op_mode(input prasq_op_e op);
        unique case (op)
            PRASQ_OP_EXT_REG, PRASQ_OP_EXT_PGR, PRASQ_OP_EXT_SGR: op_mode = PRASQ_ADDR_REG;
            PRASQ_OP_EXT_PG:  op_mode = PRASQ_ADDR_PAGE;
            PRASQ_OP_EXT_SEG: op_mode = PRASQ_ADDR_SEG;
            default:          op_mode = PRASQ_ADDR_NORMAL;
        endcase
    endfunction : op_mode

    // ------------------------------------------------------------
    // Sequence counter
    // ------------------------------------------------------------
    // Counts retirements, so multicycle ops and holds count once
    always_comb begin
        cnt_d  = cnt_q;
        mode_d = mode_q;
        if (trap_b) begin
            cnt_d  = PRASQ_CNT_ZERO;
            mode_d = PRASQ_ADDR_NORMAL;
        end else if (retire.done && retire.op != PRASQ_OP_NONE) begin
            cnt_d  = PRASQ_CNT_W'(retire.len) + PRASQ_CNT_ONE;
            mode_d = op_mode(retire.op);
        end else if (retire.done && cnt_q != PRASQ_CNT_ZERO) begin
            cnt_d = cnt_q - PRASQ_CNT_ONE;
            if (cnt_q == PRASQ_CNT_ONE) begin
                mode_d = PRASQ_ADDR_NORMAL;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q  <= PRASQ_CNT_ZERO;
            mode_q <= PRASQ_ADDR_NORMAL;
        end else begin
            cnt_q  <= cnt_d;
            mode_q <= mode_d;
        end
    end

    // Registered: active from the very next instruction, no NOP needed
    assign int_lock = (cnt_q != PRASQ_CNT_ZERO);
    assign amode    = mode_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reload_len_a: assert property (@(posedge ref_clk) disable iff (srst)
        retire.done && retire.op != PRASQ_OP_NONE && !trap_b
        |=> cnt_q == PRASQ_CNT_W'($past(retire.len)) + PRASQ_CNT_ONE)
        else $error("sequence length not loaded");
    trap_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        trap_b |=> !int_lock && amode == PRASQ_ADDR_NORMAL)
        else $error("class B trap left lock set");
    hold_count_a: assert property (@(posedge ref_clk) disable iff (srst)
        !retire.done && !trap_b |=> $stable(cnt_q))
        else $error("counter moved without retirement");
    atomic_lock_a: assert property (@(posedge ref_clk) disable iff (srst)
        retire.done && retire.op == PRASQ_OP_ATOMIC && !trap_b
        |=> int_lock && amode == PRASQ_ADDR_NORMAL)
        else $error("atomic did not lock");
    ext_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
        retire.done && retire.op == PRASQ_OP_EXT_PG && !trap_b
        |=> amode == PRASQ_ADDR_PAGE)
        else $error("page extend mode missing");
    cv_nested_c: cover property (@(posedge ref_clk)
        int_lock && retire.done && retire.op != PRASQ_OP_NONE);
    cv_trap_c: cover property (@(posedge ref_clk) int_lock && trap_b);

endmodule : prasq_seq_ctr

// file: src/prasq_top.sv
// Contract
// - On misprediction cancel every pipeline stage and flush the instruction FIFO.
// - Restart fetching at the correct target, then resume sequential prefetch.
// - Target address goes to memory the next cycle; data returns one later.
// - A 32-bit target straddling a double word needs a second fetch.
// - First target instruction bypasses the FIFO straight into decode.
// - Next targets come from fetch buffer; FIFO supplies from the fourth.
// - Atomic/extend ops block interrupts, event transfers and class A traps.
// - Two-bit length field 0..3 protects 1..4 following instructions.
// - Extend variants also change operand addressing within the sequence.
// - Lock applies to the very next instruction, any type, no NOPs.
// - Each instruction counts once, however many cycles or holds it takes.
// - Class B trap ends the sequence, dropping lock and extended addressing.
// - Remaining instructions after trap return run unlocked, normal addressing.
// - One counter; a nested sequence op reloads it with its length.
module prasq_top
    import prasq_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Misprediction from execute
    input  wire logic                     mispredict,
    input  wire logic [PRASQ_ADDR_W-1:0]  target_addr,
    input  wire logic                     target_long,
    // Program memory port
    output prasq_pmreq_s                  pm_req,
    input  wire logic                     pm_valid,
    // Fetch/decode
    input  wire logic                     fetch_ready,
    output logic                          fifo_flush,
    output logic                          prefetch_run,
    output logic                          dec_from_buffer,
    output logic                          dec_from_fifo,
    output logic                          stage_kill,
    output logic                          bubble,
    // Retirement and interrupt side
    input  wire prasq_retire_s            retire,
    input  wire logic                     trap_b,
    output logic                          int_lock,
    output prasq_amode_e                  amode
);

    // Refill states; codes 5 to 7 are illegal and fall back to RUN
    typedef enum logic [2:0] {
        PRASQ_RUN    = 3'b000,
        PRASQ_ADDR   = 3'b001,
        PRASQ_DATA   = 3'b010,
        PRASQ_SECOND = 3'b011,
        PRASQ_BYPASS = 3'b100
    } prasq_st_e;

    prasq_st_e              st_q, st_d;
    logic [PRASQ_ADDR_W-1:0] addr_q, addr_d;
    logic                   cross_q, cross_d;
    logic [1:0]             byp_q, byp_d;
    logic                   req_q, req_d;

    function automatic logic crosses(input logic [PRASQ_ADDR_W-1:0] a, input logic lng);
        crosses = lng && (a[2:0] == PRASQ_CROSS_OFS);
    endfunction : crosses

    // ------------------------------------------------------------
    // Redirect sequencer
    // ------------------------------------------------------------
    // Misprediction always wins: a new redirect overrides any refill
    always_comb begin
        st_d    = st_q;
        addr_d  = addr_q;
        cross_d = cross_q;
        byp_d   = byp_q;
        req_d   = 1'b0;
        if (mispredict) begin
            st_d    = PRASQ_ADDR;
            addr_d  = target_addr & PRASQ_DWORD_MASK;
            cross_d = crosses(target_addr, target_long);
            byp_d   = PRASQ_BYP_ZERO;
            req_d   = 1'b1;
        end else begin
            unique case (st_q)
                PRASQ_RUN: ;
                PRASQ_ADDR: begin
                    st_d = PRASQ_DATA;
                end
                PRASQ_DATA: begin
                    if (pm_valid) begin
                        if (cross_q) begin
                            st_d   = PRASQ_SECOND;
                            addr_d = addr_q + PRASQ_DWORD_BYTES;
                            req_d  = 1'b1;
                        end else begin
                            st_d = PRASQ_BYPASS;
                        end
                    end
                end
                PRASQ_SECOND: begin
                    if (pm_valid) begin
                        st_d = PRASQ_BYPASS;
                    end
                end
                PRASQ_BYPASS: begin
                    if (fetch_ready) begin
                        byp_d = byp_q + 2'h1;
                        if (byp_q == PRASQ_BYP_LAST - 2'h1) begin
                            st_d = PRASQ_RUN;
                        end
                    end
                end
                default: st_d = PRASQ_RUN;
            endcase
        end
    end

    // State registers; reset returns to plain sequential fetch
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q    <= PRASQ_RUN;
            addr_q  <= PRASQ_RESET_PC;
            cross_q <= 1'b0;
            byp_q   <= PRASQ_BYP_ZERO;
            req_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            addr_q  <= addr_d;
            cross_q <= cross_d;
            byp_q   <= byp_d;
            req_q   <= req_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Address is registered, so it appears the cycle after detection
    assign pm_req.req  = req_q;
    assign pm_req.addr = addr_q;
    assign fifo_flush  = mispredict;
    assign stage_kill  = mispredict;
    // Prefetch resumes once first target sits in the buffer
    assign prefetch_run    = (st_q == PRASQ_RUN) || (st_q == PRASQ_BYPASS);
    assign dec_from_buffer = (st_q == PRASQ_BYPASS);
    assign dec_from_fifo   = (st_q == PRASQ_RUN) && !mispredict;
    // Killed slots carry bubbles: no write, memory or flag effect
    assign bubble = (st_q != PRASQ_RUN) && (st_q != PRASQ_BYPASS);

    prasq_seq_ctr u_seq (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .retire   (retire),
        .trap_b   (trap_b),
        .int_lock (int_lock),
        .amode    (amode)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    addr_next_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict |=> pm_req.req && pm_req.addr == ($past(target_addr) & PRASQ_DWORD_MASK))
        else $error("redirect address late or wrong");
    second_fetch_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_DATA && pm_valid && cross_q && !mispredict
        |=> pm_req.req && st_q == PRASQ_SECOND)
        else $error("straddling target not refetched");
    flush_now_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict |-> fifo_flush && stage_kill)
        else $error("mispredict without flush");
    no_fifo_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict |=> !dec_from_fifo [*3])
        else $error("FIFO used during refill");
    bypass_first_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_DATA && pm_valid && !cross_q && !mispredict |=> dec_from_buffer)
        else $error("first target not bypassed");

    // ------------------------------------------------------------
    // Refill checks
    // ------------------------------------------------------------
    // Killed slots stay bubbles while the first fetch is in flight
    refill_bubble_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict |=> bubble && !prefetch_run && !dec_from_buffer)
        else $error("refill slot not a bubble");
    // A redirect restarts the sequencer from scratch
    restart_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict |=> st_q == PRASQ_ADDR && byp_q == PRASQ_BYP_ZERO)
        else $error("redirect did not restart refill");
    // Each fetch request is a single-cycle pulse
    req_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
        pm_req.req && !mispredict |=> !pm_req.req)
        else $error("fetch request held too long");
    // Wait states hold the sequencer without a fresh request
    data_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_DATA && !pm_valid && !mispredict
        |=> st_q == PRASQ_DATA && !pm_req.req)
        else $error("data wait left early");
    // Second fetch goes to the next double word
    second_addr_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_DATA && pm_valid && cross_q && !mispredict
        |=> pm_req.addr == $past(pm_req.addr) + PRASQ_DWORD_BYTES)
        else $error("second fetch address wrong");
    // Completed straddle hands the target to decode and restarts prefetch
    prefetch_restart_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_SECOND && pm_valid && !mispredict |=> prefetch_run && dec_from_buffer)
        else $error("prefetch not restarted");
    // Only a long op at the last halfword of a double word straddles
    straddle_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict && target_long && target_addr[2:0] == PRASQ_CROSS_OFS |=> cross_q)
        else $error("straddle not detected");
    // A short target never costs a second fetch
    no_straddle_a: assert property (@(posedge ref_clk) disable iff (srst)
        mispredict && !target_long |=> !cross_q)
        else $error("short target flagged as straddling");
    // Buffer keeps feeding decode while decode stalls
    buffer_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_BYPASS && !fetch_ready && !mispredict
        |=> dec_from_buffer && $stable(byp_q))
        else $error("bypass lost during stall");
    // FIFO takes over after the third buffered instruction
    fifo_resume_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_q == PRASQ_BYPASS && fetch_ready && byp_q == PRASQ_BYP_LAST - 2'h1 && !mispredict
        |=> dec_from_fifo || mispredict)
        else $error("FIFO not resumed at fourth target");
    cv_redirect_c: cover property (@(posedge ref_clk) mispredict ##2 pm_valid);
    cv_cross_c: cover property (@(posedge ref_clk) st_q == PRASQ_SECOND);
    cv_resume_c: cover property (@(posedge ref_clk)
        st_q == PRASQ_BYPASS ##1 st_q == PRASQ_RUN);

endmodule : prasq_top

// file: tb/prasq_pm_model.sv
module prasq_pm_model
    import prasq_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire prasq_pmreq_s pm_req,
    input  wire logic [1:0]   wait_n,
    output logic              pm_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] cnt_q;
    logic       busy_q;

    // ----------------------------------------
    // Memory answer timing
    // ----------------------------------------
    // Zero wait states answer the cycle after the request; waits only when asked
    always @(posedge ref_clk) begin
        if (srst) begin
            busy_q   <= 1'b0;
            cnt_q    <= 3'h0;
            pm_valid <= 1'b0;
        end else if (pm_req.req) begin
            busy_q   <= (wait_n != 2'h0);
            cnt_q    <= {1'b0, wait_n};
            pm_valid <= (wait_n == 2'h0);
        end else if (busy_q) begin
            cnt_q    <= cnt_q - 3'h1;
            busy_q   <= (cnt_q != 3'h1);
            pm_valid <= (cnt_q == 3'h1);
        end else begin
            pm_valid <= 1'b0;
        end
    end
endmodule : prasq_pm_model

// file: tb/testbench.sv
module testbench
    import prasq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    ref_clk = 1'b0;
    logic                    srst = 1'b1;
    logic                    mispredict = 1'b0;
    logic                    target_long = 1'b0;
    logic                    fetch_ready = 1'b0;
    logic                    trap_b = 1'b0;
    logic                    took_q = 1'b0;
    logic [PRASQ_ADDR_W-1:0] target_addr = '0;
    logic [PRASQ_ADDR_W-1:0] rnd_addr;
    logic [1:0]              wait_n = 2'h0;
    logic [2:0]              st_m = 3'h0;
    logic [2:0]              st;
    logic                    pm_valid, fifo_flush, prefetch_run, dec_from_buffer;
    logic                    dec_from_fifo, stage_kill, bubble, int_lock;
    prasq_pmreq_s            pm_req;
    prasq_retire_s           retire = '0;
    prasq_amode_e            amode;
    int                      mismatches = 0;
    int                      compares = 0;
    int                      cnt_m = 0;
    logic [PRASQ_ADDR_W-1:0] addr_q[$];
    logic [2:0]              seq_q[$];

    prasq_top dut_u (.ref_clk(ref_clk), .srst(srst), .mispredict(mispredict),
        .target_addr(target_addr), .target_long(target_long), .pm_req(pm_req),
        .pm_valid(pm_valid), .fetch_ready(fetch_ready), .fifo_flush(fifo_flush),
        .prefetch_run(prefetch_run), .dec_from_buffer(dec_from_buffer),
        .dec_from_fifo(dec_from_fifo), .stage_kill(stage_kill), .bubble(bubble),
        .retire(retire), .trap_b(trap_b), .int_lock(int_lock), .amode(amode));

    prasq_pm_model pm_u (.ref_clk(ref_clk), .srst(srst), .pm_req(pm_req),
        .wait_n(wait_n), .pm_valid(pm_valid));

    // Clock at 250 MHz
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("mismatches %0d, compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [1:0] amode_of(prasq_op_e op);
        case (op)
            PRASQ_OP_ATOMIC:  return PRASQ_ADDR_NORMAL;
            PRASQ_OP_EXT_PG:  return PRASQ_ADDR_PAGE;
            PRASQ_OP_EXT_SEG: return PRASQ_ADDR_SEG;
            default:          return PRASQ_ADDR_REG;
        endcase
    endfunction : amode_of

    // One retirement, then a random hold to mimic multi-cycle instructions
    task automatic step(prasq_op_e op, logic [1:0] len, logic trap);
        @(posedge ref_clk);
        retire <= '{1'b1, op, len};
        trap_b <= trap;
        if (trap) begin
            cnt_m = 0;
        end else if (op != PRASQ_OP_NONE) begin
            cnt_m = len + 1;
            st_m  = {1'b1, amode_of(op)};
        end else if (cnt_m > 0) begin
            cnt_m--;
        end
        if (cnt_m == 0) begin
            st_m = 3'h0;
        end
        seq_q.push_back(st_m);
        @(posedge ref_clk);
        retire <= '0;
        trap_b <= 1'b0;
        repeat ($urandom_range(2)) @(posedge ref_clk);
    endtask : step

    task automatic redirect(logic [PRASQ_ADDR_W-1:0] a, logic lng, logic [1:0] w);
        int n;
        @(posedge ref_clk);
        mispredict  <= 1'b1;
        target_addr <= a;
        target_long <= lng;
        wait_n      <= w;
        addr_q.push_back(a & PRASQ_DWORD_MASK);
        if (lng && a[2:0] == PRASQ_CROSS_OFS) begin
            addr_q.push_back((a & PRASQ_DWORD_MASK) + PRASQ_DWORD_BYTES);
        end
        #1;
        chk("fifo_flush", 1, fifo_flush);
        chk("stage_kill", 1, stage_kill);
        chk("dec_from_fifo", 0, dec_from_fifo);
        @(posedge ref_clk);
        mispredict <= 1'b0;
        #1;
        chk("pm_req.req", 1, pm_req.req);
        chk("bubble", 1, bubble);
        chk("prefetch_run", 0, prefetch_run);
        n = 0;
        while (dec_from_buffer !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("fetches left", 0, addr_q.size());
        chk("prefetch_run", 1, prefetch_run);
        chk("dec_from_buffer", 1, dec_from_buffer);
        @(posedge ref_clk);
        fetch_ready <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("dec_from_buffer", 1, dec_from_buffer);
        @(posedge ref_clk);
        fetch_ready <= 1'b0;
        #1;
        chk("dec_from_fifo", 1, dec_from_fifo);
        chk("bubble", 0, bubble);
    endtask : redirect

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    // Lock state settles one edge after a retirement or trap
    always @(posedge ref_clk) took_q <= retire.done | trap_b;
    always @(negedge ref_clk) begin
        if (took_q && seq_q.size() > 0) begin
            st = seq_q.pop_front();
            chk("int_lock", st[2], int_lock);
            chk("amode", st[1:0], amode);
        end
        if (pm_req.req && addr_q.size() > 0) begin
            chk("pm_req.addr", addr_q.pop_front(), pm_req.addr);
        end
    end

    // Run is a few hundred cycles; this is ample
    initial begin
        #40000;
        mismatches++;
        $display("unexpected watchdog: expected end, seen hang");
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h50fe_811e));
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk("int_lock", 0, int_lock);
        chk("dec_from_fifo", 1, dec_from_fifo);
        redirect(24'h00_1234, 1'b0, 2'h0);
        redirect(24'h00_2346, 1'b1, 2'h0);
        redirect(24'h00_0106, 1'b0, 2'h1);
        rnd_addr = PRASQ_ADDR_W'($urandom);
        redirect((rnd_addr | 24'h00_0006) & 24'hff_fffe, 1'b1, 2'h2);
        for (int i = 1; i < 7; i++) begin
            for (int j = 0; j < 4; j++) begin
                step(prasq_op_e'(i), 2'(j), 1'b0);
                repeat (j + 1) step(PRASQ_OP_NONE, 2'h0, 1'b0);
            end
        end
        step(PRASQ_OP_NONE, 2'h0, 1'b0);
        step(PRASQ_OP_ATOMIC, 2'h3, 1'b0);
        step(PRASQ_OP_NONE, 2'h0, 1'b0);
        step(PRASQ_OP_EXT_SEG, 2'h0, 1'b0);
        step(PRASQ_OP_NONE, 2'h0, 1'b0);
        step(PRASQ_OP_EXT_PG, 2'h3, 1'b0);
        step(PRASQ_OP_NONE, 2'h0, 1'b1);
        repeat (2) step(PRASQ_OP_NONE, 2'h0, 1'b0);
        repeat (4) @(posedge ref_clk);
        print_verdict();
    end
endmodule : testbench
